// [src/miw_pkg.sv]
package miw_pkg;
  localparam logic [7:0]  FLAGS_OFS    = 8'h00;
  localparam logic [7:0]  ENABLE_OFS   = 8'h04;
  localparam logic [7:0]  WAKECFG_OFS  = 8'h08;
  localparam logic [7:0]  SHADOW_OFS   = 8'h10;
  localparam int          SRC_LSB      = 4;
  localparam int          CONV_BIT     = 3;
  localparam int          CMP_BIT      = 2;
  localparam int          TMR_BIT      = 1;
  localparam int          PIN_BIT      = 0;
  localparam int          GIE_BIT      = 0;
  localparam int          WUR_BIT      = 0;
  localparam int          CMP1_WK_BIT  = 0;
  localparam int          CMP2_WK_BIT  = 1;
  localparam int          PIN_WK_BIT   = 2;
  localparam logic [3:0]  FLAGS_RST    = 4'h0;
  localparam logic [3:0]  ENABLE_RST   = 4'h0;
  localparam logic [2:0]  WAKECFG_RST  = 3'h0;
  localparam logic [11:0] IRQ_VECTOR   = 12'h004;
  typedef enum logic [1:0] {ST_RUN, ST_ISR, ST_SLEEP, ST_STEP} miw_state_type;
endpackage

// [src/miw_ctrl.sv]
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module miw_ctrl (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // event sources, one-cycle pulses
  input  wire logic        EVT_TIMER_OVF,
  input  wire logic        EVT_CONV_DONE,
  input  wire logic        EVT_CMP1_CHG,
  input  wire logic        EVT_CMP2_CHG,
  input  wire logic        EVT_PIN_CHG,
  // core control
  input  wire logic        CORE_SLEEP,
  input  wire logic        CORE_STEP_DONE,
  input  wire logic        CORE_RETURN_FROM_ISR,
  output logic             VEC_REQ,
  output logic [11:0]      VEC_ADDR,
  output logic             CTX_SEL,
  output logic             WAKE,
  output logic             WAKE_RESET,
  // core context access
  input  wire logic        CTX_WE,
  input  wire logic [1:0]  CTX_ADDR,
  input  wire logic [7:0]  CTX_WDATA,
  output logic [7:0]      CTX_RDATA
);

  typedef struct packed {
    miw_pkg::miw_state_type st;
    logic                   global_irq_enable;
    logic [3:0]             flags;
    logic [3:0]             en;
    logic                   wake_reset_en;
    logic [2:0]             wkcfg;
    logic [1:0][3:0][7:0]   ctx;
    logic                   vec;
    logic                   wake;
    logic                   wrst;
    logic [7:0]             prdata;
    logic                   perr;
    logic [7:0]             crd;
  } miw_regs_type;

  miw_regs_type q;
  miw_regs_type d;
  miw_regs_type rst_val;

  logic [3:0] sets;
  logic [3:0] pend;
  logic       wr;
  logic       setup;
  logic       wr_flg;
  logic       bank;
  logic       wrst_now;

  ////////////////////////////////////////////////////////////////////////////
  // event qualification

  always_comb begin
    sets                     = '0;
    sets[miw_pkg::CONV_BIT]  = EVT_CONV_DONE;
    sets[miw_pkg::TMR_BIT]   = EVT_TIMER_OVF;
    sets[miw_pkg::CMP_BIT]   = (EVT_CMP1_CHG & q.wkcfg[miw_pkg::CMP1_WK_BIT])
                             | (EVT_CMP2_CHG & q.wkcfg[miw_pkg::CMP2_WK_BIT]);
    sets[miw_pkg::PIN_BIT]   = EVT_PIN_CHG & q.wkcfg[miw_pkg::PIN_WK_BIT];
  end

  // only enabled sources may vector or wake
  assign pend   = q.flags & q.en;
  assign setup  = PSEL & ~PENABLE;
  assign wr     = PSEL & PENABLE & PWRITE;
  assign wr_flg = wr && PADDR == miw_pkg::FLAGS_OFS;
  // shadow bank is in use while in the service routine
  assign bank   = (q.st == miw_pkg::ST_ISR);
  // a wake reset wipes every flag, so the flag checks skip that cycle
  assign wrst_now = (q.st == miw_pkg::ST_SLEEP) && q.wake_reset_en && (|pend);

  always_comb begin
    rst_val       = '0;
    rst_val.st    = miw_pkg::ST_RUN;
    rst_val.flags = miw_pkg::FLAGS_RST;
    rst_val.en    = miw_pkg::ENABLE_RST;
    rst_val.wkcfg = miw_pkg::WAKECFG_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d      = q;
    d.vec  = 1'b0;
    d.wake = 1'b0;
    d.wrst = 1'b0;

    // read data captured in the setup cycle so the access phase needs no wait
    if (setup) begin
      d.perr   = 1'b0;
      d.prdata = 8'h00;
      case (PADDR)
        miw_pkg::FLAGS_OFS:  d.prdata = {q.flags, 3'b000, q.global_irq_enable};
        miw_pkg::ENABLE_OFS: d.prdata = {q.en, 3'b000, q.wake_reset_en};
        miw_pkg::WAKECFG_OFS: d.prdata = {5'h00, q.wkcfg};
        miw_pkg::SHADOW_OFS, miw_pkg::SHADOW_OFS + 8'h04,
        miw_pkg::SHADOW_OFS + 8'h08, miw_pkg::SHADOW_OFS + 8'h0C:
          d.prdata = q.ctx[~bank][PADDR[3:2]];
        default: d.perr = 1'b1;
      endcase
    end

    if (wr) begin
      case (PADDR)
        miw_pkg::FLAGS_OFS: begin
          d.flags = PWDATA[7:miw_pkg::SRC_LSB];
          d.global_irq_enable   = PWDATA[miw_pkg::GIE_BIT];
        end
        miw_pkg::ENABLE_OFS: begin
          d.en  = PWDATA[7:miw_pkg::SRC_LSB];
          d.wake_reset_en = PWDATA[miw_pkg::WUR_BIT];
        end
        miw_pkg::WAKECFG_OFS: d.wkcfg = PWDATA[2:0];
        miw_pkg::SHADOW_OFS, miw_pkg::SHADOW_OFS + 8'h04,
        miw_pkg::SHADOW_OFS + 8'h08, miw_pkg::SHADOW_OFS + 8'h0C:
          d.ctx[~bank][PADDR[3:2]] = PWDATA[7:0];
        default: ;
      endcase
    end

    // core context goes to the bank of the current mode only
    if (CTX_WE) begin
      d.ctx[bank][CTX_ADDR] = CTX_WDATA;
    end
    d.crd = d.ctx[bank][CTX_ADDR];

    // a hardware set beats a software clear in the same cycle
    d.flags = d.flags | sets;

    case (q.st)
      miw_pkg::ST_RUN: begin
        if (CORE_SLEEP) begin
          d.st = miw_pkg::ST_SLEEP;
        end else if (q.global_irq_enable && |pend) begin
          d.vec = 1'b1;
          d.global_irq_enable = 1'b0;
          d.st  = miw_pkg::ST_ISR;
        end
      end
      miw_pkg::ST_ISR: begin
        if (CORE_RETURN_FROM_ISR) begin
          d.global_irq_enable = 1'b1;
          d.st  = miw_pkg::ST_RUN;
        end
      end
      miw_pkg::ST_SLEEP: begin
        if (|pend) begin
          if (q.wake_reset_en) begin
            d      = rst_val;
            d.wrst = 1'b1;
          end else begin
            d.wake = 1'b1;
            d.st   = q.global_irq_enable ? miw_pkg::ST_STEP : miw_pkg::ST_RUN;
          end
        end
      end
      miw_pkg::ST_STEP: begin
        // instruction after sleep has run; vector only now
        if (CORE_STEP_DONE) begin
          if (q.global_irq_enable && |pend) begin
            d.vec = 1'b1;
            d.global_irq_enable = 1'b0;
            d.st  = miw_pkg::ST_ISR;
          end else begin
            d.st = miw_pkg::ST_RUN;
          end
        end
      end
      default: d.st = miw_pkg::ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= '0;
    end else if (CE) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign PREADY     = PSEL & PENABLE;
  assign PRDATA     = {24'h000000, q.prdata};
  assign PSLVERR    = PSEL & PENABLE & q.perr;
  assign VEC_REQ    = q.vec;
  assign VEC_ADDR   = miw_pkg::IRQ_VECTOR;
  assign CTX_SEL    = bank;
  assign WAKE       = q.wake;
  assign WAKE_RESET = q.wrst;
  assign CTX_RDATA  = q.crd;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_sleep_hit;
    CE && q.st == miw_pkg::ST_SLEEP && |pend;
  endsequence

  sequence s_run_take;
    CE && q.st == miw_pkg::ST_RUN && !CORE_SLEEP && q.global_irq_enable && |pend;
  endsequence

  a_timer_flag_set: assert property (
    CE && EVT_TIMER_OVF && !wrst_now |=> q.flags[miw_pkg::TMR_BIT])
    else $error("timer event lost");

  a_cmp_flag_gate: assert property (
    CE && !q.flags[miw_pkg::CMP_BIT] && !wr_flg
    && !(EVT_CMP1_CHG && q.wkcfg[miw_pkg::CMP1_WK_BIT]) && !(EVT_CMP2_CHG && q.wkcfg[miw_pkg::CMP2_WK_BIT])
    |=> !q.flags[miw_pkg::CMP_BIT])
    else $error("comparator flag set without wake enable");

  a_pin_flag_gate: assert property (
    CE && !q.wkcfg[miw_pkg::PIN_WK_BIT] && !q.flags[miw_pkg::PIN_BIT] && !wr_flg
    |=> !q.flags[miw_pkg::PIN_BIT])
    else $error("pin flag set without pin wake enable");

  a_vector_take: assert property (
    s_run_take |=> VEC_REQ && !q.global_irq_enable && CTX_SEL ##1 !VEC_REQ)
    else $error("vector entry wrong");

  a_no_vec_gie: assert property (
    CE && !q.global_irq_enable |=> !VEC_REQ)
    else $error("vector taken with global enable clear");

  a_return_from_isr_exit: assert property (
    CE && q.st == miw_pkg::ST_ISR && CORE_RETURN_FROM_ISR |=> q.global_irq_enable && !CTX_SEL)
    else $error("return did not restore context and enable");

  a_wake_step: assert property (
    s_sleep_hit ##0 !q.wake_reset_en && q.global_irq_enable |=> WAKE && !VEC_REQ && q.st == miw_pkg::ST_STEP)
    else $error("wake did not wait for next instruction");

  a_wake_reset: assert property (
    s_sleep_hit ##0 q.wake_reset_en |=> WAKE_RESET && !WAKE && q.en == 4'h0 && !q.global_irq_enable)
    else $error("wake reset not produced");

  a_reserved_zero: assert property (
    $past(CE) && PSEL && PENABLE
    && (PADDR == miw_pkg::FLAGS_OFS || PADDR == miw_pkg::ENABLE_OFS)
    |-> PRDATA[3:1] == 3'b000)
    else $error("reserved bits not zero");

  a_timer_hold: assert property (
    CE && q.flags[miw_pkg::TMR_BIT] && !wr_flg && !(q.st == miw_pkg::ST_SLEEP && q.wake_reset_en)
    |=> q.flags[miw_pkg::TMR_BIT])
    else $error("timer flag cleared by hardware");

  a_conv_flag_set: assert property (
    CE && EVT_CONV_DONE && !wrst_now |=> q.flags[miw_pkg::CONV_BIT])
    else $error("converter event lost");

  a_cmp_flag_set: assert property (
    CE && !wrst_now && ((EVT_CMP1_CHG && q.wkcfg[miw_pkg::CMP1_WK_BIT])
    || (EVT_CMP2_CHG && q.wkcfg[miw_pkg::CMP2_WK_BIT])) |=> q.flags[miw_pkg::CMP_BIT])
    else $error("enabled comparator change lost");

  a_pin_flag_set: assert property (
    CE && !wrst_now && EVT_PIN_CHG && q.wkcfg[miw_pkg::PIN_WK_BIT] |=> q.flags[miw_pkg::PIN_BIT])
    else $error("enabled pin change lost");

  a_single_vector: assert property (
    CE && VEC_REQ |=> !VEC_REQ)
    else $error("vector request repeated");

  a_no_en_vec: assert property (
    CE && (q.flags & q.en) == 4'h0 |=> !VEC_REQ)
    else $error("vector without an enabled source");

  a_isr_ctx_keep: assert property (
    CE && q.st == miw_pkg::ST_ISR && !(wr && (PADDR & 8'hF0) == miw_pkg::SHADOW_OFS)
    |=> $stable(q.ctx[0]))
    else $error("main context changed in service routine");

  a_wake_inline: assert property (
    s_sleep_hit ##0 !q.wake_reset_en && !q.global_irq_enable |=> WAKE && !VEC_REQ && q.st == miw_pkg::ST_RUN)
    else $error("inline wake wrong");

  a_step_vector: assert property (
    CE && q.st == miw_pkg::ST_STEP && CORE_STEP_DONE && q.global_irq_enable && |pend
    |=> VEC_REQ && CTX_SEL && !q.global_irq_enable)
    else $error("vector after step missing");

  a_reset_state: assert property (
    WAKE_RESET |-> q.en == 4'h0 && !q.wake_reset_en && !q.global_irq_enable && q.flags == 4'h0)
    else $error("wake reset left enables set");

endmodule // miw_ctrl

// [tb/miw_core_model.sv]
`timescale 1ns/1ps
module miw_core_model (
  // clock
  input  wire logic CLK,
  // controller outputs
  input  wire logic VEC_REQ,
  input  wire logic WAKE,
  input  wire logic WAKE_RESET,
  // stall choice
  input  wire logic SLOW,
  // back to controller
  output logic      CORE_STEP_DONE
);
  int n_vec  = 0;
  int n_wake = 0;
  int n_rst  = 0;
  initial CORE_STEP_DONE = 1'b0;
  ////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    if (VEC_REQ)
      n_vec <= n_vec + 1;
    if (WAKE_RESET)
      n_rst <= n_rst + 1;
  end
  // a slow core shows whether the vector really waits for the step
  always @(posedge CLK) begin
    if (WAKE) begin
      n_wake <= n_wake + 1;
      repeat (SLOW ? 4 : 1) @(posedge CLK);
      CORE_STEP_DONE <= 1'b1;
      @(posedge CLK);
      CORE_STEP_DONE <= 1'b0;
    end
  end
endmodule // miw_core_model

// [tb/miw_ctrl_tb.sv]
`timescale 1ns/1ps
module miw_ctrl_tb;
  logic        clk, sys_rst, psel, penable, pwrite, ctx_we, slow, err;
  logic        pready, pslverr, vec_req, ctx_sel, wake, wake_reset, step_done;
  logic [7:0]  paddr, ctx_wdata, ctx_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  ev;
  logic [1:0]  ctx_addr;
  logic [11:0] vec_addr;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  ////////////////////////////////////////////////////////////
  miw_ctrl dut_u (.CLK(clk), .SYS_RST(sys_rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .EVT_TIMER_OVF(ev[2]), .EVT_CONV_DONE(ev[3]), .EVT_CMP1_CHG(ev[4]),
    .EVT_CMP2_CHG(ev[5]), .EVT_PIN_CHG(ev[6]), .CORE_SLEEP(ev[1]), .CORE_STEP_DONE(step_done),
    .CORE_RETURN_FROM_ISR(ev[0]), .VEC_REQ(vec_req), .VEC_ADDR(vec_addr), .CTX_SEL(ctx_sel), .WAKE(wake),
    .WAKE_RESET(wake_reset), .CTX_WE(ctx_we), .CTX_ADDR(ctx_addr), .CTX_WDATA(ctx_wdata),
    .CTX_RDATA(ctx_rdata));
  miw_core_model core_u (.CLK(clk), .VEC_REQ(vec_req), .WAKE(wake), .WAKE_RESET(wake_reset),
    .SLOW(slow), .CORE_STEP_DONE(step_done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h000000, exp});
  endtask
  task pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    repeat (2) @(posedge clk);
  endtask
  // read data lags the address by one cycle
  task ctx(input logic w, input logic [7:0] d);
    @(posedge clk);
    ctx_we <= w;
    ctx_addr <= 2'h0;
    ctx_wdata <= d;
    @(posedge clk);
    ctx_we <= 1'b0;
    @(posedge clk);
    rd = {24'h000000, ctx_rdata};
  endtask
  task sleep_evt(input int wait_n);
    pulse(7'h02);
    pulse(7'h04);
    repeat (wait_n) @(posedge clk);
  endtask
  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, psel, penable, pwrite, ctx_we, slow} = 6'h20;
    {paddr, pwdata, ev, ctx_addr, ctx_wdata} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(8'h00, 8'h00, "flags rst");
    rchk(8'h04, 8'h00, "en rst");
    apb(1'b1, 8'h04, 8'hFF);
    rchk(8'h04, 8'hF1, "en bits");
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h00, 8'h0E);
    rchk(8'h00, 8'h00, "flags unimpl");
    apb(1'b0, 8'h0C, 8'h00);
    chk("slverr", {31'h0, err}, 32'h1);
    pulse(7'h14);
    pulse(7'h48);
    rchk(8'h00, 8'hA0, "flags evt");
    apb(1'b1, 8'h08, 8'h07);
    pulse(7'h60);
    rchk(8'h00, 8'hF0, "flags wake");
    apb(1'b1, 8'h04, 8'h20);
    ctx(1'b1, 8'h11);
    chk("no vec", core_u.n_vec, 0);
    apb(1'b1, 8'h00, 8'hA1);
    repeat (3) @(posedge clk);
    chk("vec once", core_u.n_vec, 1);
    chk("vec addr", {20'h0, vec_addr}, 32'h4);
    chk("isr ctx", {31'h0, ctx_sel}, 32'h1);
    rchk(8'h00, 8'hA0, "gie clr");
    ctx(1'b1, 8'h22);
    ctx(1'b0, 8'h00);
    chk("isr acc", rd, 32'h22);
    rchk(8'h10, 8'h11, "view main");
    apb(1'b1, 8'h14, 8'h33);
    rchk(8'h14, 8'h33, "view write");
    apb(1'b1, 8'h00, 8'h00);
    pulse(7'h01);
    chk("main ctx", {31'h0, ctx_sel}, 32'h0);
    rchk(8'h00, 8'h01, "gie set");
    ctx(1'b0, 8'h00);
    chk("main acc", rd, 32'h11);
    rchk(8'h10, 8'h22, "view isr");
    pulse(7'h08);
    chk("no en vec", core_u.n_vec, 1);
    slow <= 1'b1;
    sleep_evt(0);
    chk("step first", core_u.n_vec, 1);
    repeat (12) @(posedge clk);
    chk("wake vec", core_u.n_vec, 2);
    apb(1'b1, 8'h00, 8'h00);
    pulse(7'h01);
    apb(1'b1, 8'h00, 8'h00);
    sleep_evt(12);
    chk("inline", core_u.n_vec, 2);
    chk("wakes", core_u.n_wake, 2);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h04, 8'h21);
    sleep_evt(4);
    chk("wake rst", core_u.n_rst, 1);
    chk("rst no vec", core_u.n_vec, 2);
    rchk(8'h04, 8'h00, "en after");
    end_sim;
  end
  // generous bound, the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule // miw_ctrl_tb
